// >>> design/sio_diag.sv
/*
	Channel diagnostics for one safety output and one even/odd input pair:
	readback, overcurrent, open load, discrepancy and the module fail-safe latch.
	Assumes field inputs are synchronous to mclk and the pair inputs debounced.
*/
// Notes on behaviour
// - Compare driven output with commanded value continuously.
// - External readback must match within maximum time.
// - Zero readback delay means no waiting.
// - Each fault: fail-safe or report per option.
// - Overcurrent on outputs; inputs only with pulses.
// - Three recovery policies: failsafe, auto, none.
// - Auto: trip off, clear after recovery time.
// - None: stay off until supply cycled.
// - Energized output below current threshold: open load.
// - Pair even with odd, fault on even.
// - Equivalent agree, complementary oppose within time.
// - Low is safe; value follows active level.
// - Two lone toggles of one input fault.
// - Monitor only debounced pair levels.
`default_nettype none

module sio_diag (
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// Configuration
	input wire sio_pkg::sio_out_cfg_s out_cfg,
	input wire sio_pkg::sio_in_cfg_s in_cfg,
	// User program side
	input wire logic out_cmd,
	input wire logic pair_clear,
	// Output channel field side
	input wire logic out_sense,
	input wire logic ext_readback,
	input wire logic out_load_low,
	input wire logic out_overcurrent,
	output logic output_channel,
	// Input pair field side
	input wire logic even_in,
	input wire logic odd_in,
	input wire logic in_overcurrent,
	input wire logic supply_ok,
	// Fault flags
	output logic output_readback_fault,
	output logic output_overcurrent_fault,
	output logic output_open_load_fault,
	output logic input_overcurrent_fault,
	output logic pair_mismatch_fault,
	// Pair results and module state
	output logic pair_value,
	output logic pair_safe,
	output logic failsafe
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	// Time base
	logic [sio_pkg::TICK_W-1:0] tick_cnt; // Cycles within one tick
	logic tick; // One-cycle time base pulse
	// Output drive
	logic next_drive; // Level the output will take
	logic oc_out_allow; // Output not held off by overcurrent
	logic oc_out_fs; // Output overcurrent asks fail-safe
	// Input overcurrent
	logic oc_in_en; // Input overcurrent armed
	logic oc_in_fs; // Input overcurrent asks fail-safe
	// Readback
	logic int_mm; // Sensed level differs from drive
	logic ext_mm; // External readback differs from drive
	logic [sio_pkg::CNT_W-1:0] rb_timer; // Ticks of external mismatch
	logic ext_expired; // External allowance used up
	// Fail-safe causes
	logic fs_cause; // Any fault that selected fail-safe

	// ------------------------------------------------------------
	// Common time base
	// ------------------------------------------------------------
	// Divide mclk down to the diagnostic tick
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tick_cnt <= sio_pkg::TICK_RST;
		else if (ce)
			tick_cnt <= (tick_cnt == sio_pkg::TICK_LAST) ? sio_pkg::TICK_RST
				: tick_cnt + sio_pkg::TICK_STEP;
	end

	// Tick pulse, frozen with the rest when ce is low
	assign tick = ce && (tick_cnt == sio_pkg::TICK_LAST);

	// ------------------------------------------------------------
	// Output drive
	// ------------------------------------------------------------
	// Command passes only when overcurrent and fail-safe allow
	assign next_drive = out_cmd && oc_out_allow && !failsafe;

	// Output level register, de-energized after reset
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			output_channel <= 1'b0;
		else if (ce)
			output_channel <= next_drive;
	end

	// ------------------------------------------------------------
	// Overcurrent
	// ------------------------------------------------------------
	// Outputs may arm it in any configuration
	sio_ocp u_oc_out (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.tick(tick),
		.en(out_cfg.oc_en),
		.policy(out_cfg.oc_policy),
		.recov_time(out_cfg.recov_time),
		.overcurrent(out_overcurrent),
		.supply_ok(supply_ok),
		.fault(output_overcurrent_fault),
		.allow(oc_out_allow),
		.failsafe_req(oc_out_fs)
	);

	// Inputs only arm it when test pulses drive them
	assign oc_in_en = in_cfg.oc_en && in_cfg.test_pulse;

	sio_ocp u_oc_in (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.tick(tick),
		.en(oc_in_en),
		.policy(in_cfg.oc_policy),
		.recov_time(in_cfg.recov_time),
		.overcurrent(in_overcurrent),
		.supply_ok(supply_ok),
		.fault(input_overcurrent_fault),
		.allow(),
		.failsafe_req(oc_in_fs)
	);

	// ------------------------------------------------------------
	// Readback
	// ------------------------------------------------------------
	// Internal sense is expected to follow the drive at once
	assign int_mm = (out_sense != output_channel);
	// External point may lag by the configured delay
	assign ext_mm = (ext_readback != output_channel);
	// Zero delay makes any mismatch expire immediately
	assign ext_expired = ext_mm && (rb_timer >= out_cfg.rb_delay);

	// Propagation timer restarts on match or a new drive level
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rb_timer <= sio_pkg::CNT_RST;
		else if (ce)
		begin
			if (!ext_mm || next_drive != output_channel)
				rb_timer <= sio_pkg::CNT_RST;
			else
				rb_timer <= sio_pkg::sio_count(rb_timer, tick);
		end
	end

	// Readback flag follows the selected comparison
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			output_readback_fault <= 1'b0;
		else if (ce)
		begin
			if (out_cfg.ext_rb)
				output_readback_fault <= ext_expired;
			else
				output_readback_fault <= int_mm;
		end
	end

	// ------------------------------------------------------------
	// Open load
	// ------------------------------------------------------------
	// Only an energized output can show too little current
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			output_open_load_fault <= 1'b0;
		else if (ce)
			output_open_load_fault <= out_cfg.ol_en && output_channel && out_load_low;
	end

	// ------------------------------------------------------------
	// Input pair
	// ------------------------------------------------------------
	// Configured on the even channel, watches both
	sio_pair u_pair (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.tick(tick),
		.en(in_cfg.disc_en),
		.mode(in_cfg.disc_mode),
		.active_low(in_cfg.active_low),
		.disc_time(in_cfg.disc_time),
		.even_in(even_in),
		.odd_in(odd_in),
		.clear(pair_clear),
		.fault(pair_mismatch_fault),
		.value(pair_value),
		.safe(pair_safe)
	);

	// ------------------------------------------------------------
	// Module fail-safe
	// ------------------------------------------------------------
	// Faults with fail-safe selected; others are reported, and output overcurrent also holds the output off
	assign fs_cause = (output_readback_fault && out_cfg.rb_failsafe)
		|| (output_open_load_fault && out_cfg.ol_failsafe)
		|| (pair_mismatch_fault && in_cfg.disc_failsafe)
		|| oc_out_fs || oc_in_fs;

	// Latched until reset; it de-energizes the output
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			failsafe <= 1'b0;
		else if (ce && fs_cause)
			failsafe <= 1'b1;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_internal_rb: assert property (ce && !out_cfg.ext_rb && int_mm
		|=> output_readback_fault)
		else $error("internal readback mismatch not flagged");
	a_zero_delay: assert property (ce && out_cfg.ext_rb
		&& out_cfg.rb_delay == sio_pkg::CNT_RST && ext_mm |=> output_readback_fault)
		else $error("zero readback delay still waited");
	a_delay_held: assert property (ce && out_cfg.ext_rb
		&& out_cfg.rb_delay != sio_pkg::CNT_RST && rb_timer == sio_pkg::CNT_RST
		|=> !output_readback_fault)
		else $error("readback fault before the allowance");
	a_open_load: assert property (ce && out_cfg.ol_en && output_channel && out_load_low
		|=> output_open_load_fault)
		else $error("open load on energized output missed");
	a_oc_deenergize: assert property (ce && output_overcurrent_fault
		|=> !output_channel)
		else $error("output energized during overcurrent fault");
	a_failsafe_off: assert property (ce && failsafe |=> failsafe && !output_channel)
		else $error("fail-safe released or output left on");

	// Drive register follows the gated command
	a_drive_follow: assert property (ce |=> output_channel == $past(next_drive))
		else $error("output drive missed its command");

	// Internal flag drops once sense agrees
	a_int_clear: assert property (ce && !out_cfg.ext_rb && !int_mm
		|=> !output_readback_fault)
		else $error("internal readback fault without mismatch");

	// External flag drops once readback agrees
	a_ext_clear: assert property (ce && out_cfg.ext_rb && !ext_mm
		|=> !output_readback_fault)
		else $error("external readback fault without mismatch");

	// Open load needs an energized output
	a_open_idle: assert property (ce && !output_channel
		|=> !output_open_load_fault)
		else $error("open load flagged on idle output");

	// Disarmed output overcurrent never trips
	a_out_oc_off: assert property (ce && !out_cfg.oc_en && !output_overcurrent_fault
		|=> !output_overcurrent_fault)
		else $error("disarmed output overcurrent tripped");

	// Inputs without test pulses never trip
	a_in_oc_off: assert property (ce && !oc_in_en && !input_overcurrent_fault
		|=> !input_overcurrent_fault)
		else $error("input overcurrent tripped without test pulses");

	// Any selected cause latches fail-safe
	a_fs_latch: assert property (ce && fs_cause |=> failsafe)
		else $error("fail-safe cause not latched");

	// Time base pulse lasts one cycle
	a_tick_once: assert property (tick |=> !tick)
		else $error("time base pulse stretched");

	// Main scenarios reached
	c_failsafe: cover property (!failsafe ##1 failsafe);
	c_ext_fault: cover property (out_cfg.ext_rb && !output_readback_fault ##1 output_readback_fault);

endmodule : sio_diag

`default_nettype wire

// >>> common/sio_pkg.sv
/*
	Shared constants, types and helpers for the safety I/O channel diagnostics.
	Assumes a single 100 MHz mclk and a diagnostic time base of 1 us ticks.
*/
`default_nettype none

package sio_pkg;

	// ------------------------------------------------------------
	// Clock and time base
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000;
	// Cycles per tick, least time rounded up
	localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 7;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
	localparam logic [TICK_W-1:0] TICK_RST = 7'h00;
	localparam logic [TICK_W-1:0] TICK_STEP = 7'h01;

	// ------------------------------------------------------------
	// Delay counters and toggle counters
	// ------------------------------------------------------------
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
	localparam logic [1:0] EDGE_RST = 2'h0;
	localparam logic [1:0] EDGE_ONE = 2'h1;
	localparam logic [1:0] EDGE_LIMIT = 2'h2;

	// ------------------------------------------------------------
	// Modes and states
	// ------------------------------------------------------------
	// Overcurrent recovery policy
	typedef enum logic [1:0] {
		OCP_FAILSAFE = 2'h0,
		OCP_AUTO = 2'h1,
		OCP_NONE = 2'h2
	} sio_ocp_e;
	// Overcurrent channel state, Gray along ok, recover, locked
	typedef enum logic [1:0] {
		OCS_OK = 2'h0,
		OCS_RECOVER = 2'h1,
		OCS_LOCKED = 2'h3
	} sio_ocs_e;
	// Input pair relationship
	typedef enum logic {
		PAIR_EQUIV = 1'b0,
		PAIR_COMPL = 1'b1
	} sio_pair_e;

	// ------------------------------------------------------------
	// Configuration carriers
	// ------------------------------------------------------------
	// Output channel setup
	typedef struct packed {
		logic ext_rb;
		logic [CNT_W-1:0] rb_delay;
		logic rb_failsafe;
		logic ol_en;
		logic ol_failsafe;
		logic oc_en;
		sio_ocp_e oc_policy;
		logic [CNT_W-1:0] recov_time;
	} sio_out_cfg_s;
	// Input pair setup, held on the even channel
	typedef struct packed {
		logic test_pulse;
		logic oc_en;
		sio_ocp_e oc_policy;
		logic [CNT_W-1:0] recov_time;
		logic disc_en;
		sio_pair_e disc_mode;
		logic active_low;
		logic disc_failsafe;
		logic [CNT_W-1:0] disc_time;
	} sio_in_cfg_s;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Saturating tick counter step
	function automatic logic [CNT_W-1:0] sio_count(input logic [CNT_W-1:0] cnt,
		input logic tick);
		sio_count = (tick && cnt != CNT_MAX) ? cnt + CNT_STEP : cnt;
	endfunction : sio_count

endpackage : sio_pkg

`default_nettype wire

// >>> design/sio_ocp.sv
/*
	Overcurrent response for one channel: trip, timed auto recovery or lockout.
	Assumes tick is a one-cycle pulse of the common time base, gated by ce.
*/
`default_nettype none

module sio_ocp (
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	// Configuration
	input wire logic en,
	input wire sio_pkg::sio_ocp_e policy,
	input wire logic [sio_pkg::CNT_W-1:0] recov_time,
	// Field side
	input wire logic overcurrent,
	input wire logic supply_ok,
	// Status
	output logic fault,
	output logic allow,
	output logic failsafe_req
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	sio_pkg::sio_ocs_e state; // Channel state
	sio_pkg::sio_ocs_e next_state; // Next channel state
	logic [sio_pkg::CNT_W-1:0] timer; // Recovery time elapsed, ticks

	// Transition decisions
	always_comb
	begin
		next_state = state;
		unique case (state)
			sio_pkg::OCS_OK:
				// Trip: auto goes to timed recovery, others lock
				if (en && overcurrent)
					next_state = (policy == sio_pkg::OCP_AUTO) ? sio_pkg::OCS_RECOVER
						: sio_pkg::OCS_LOCKED;
			sio_pkg::OCS_RECOVER:
				// Clear after recovery time, retrip if still over
				if (!en || timer >= recov_time)
					next_state = sio_pkg::OCS_OK;
			sio_pkg::OCS_LOCKED:
				// Only a field supply cycle releases the lock
				if (!supply_ok)
					next_state = sio_pkg::OCS_OK;
			default:
				next_state = sio_pkg::OCS_OK;
		endcase
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			state <= sio_pkg::OCS_OK;
		else if (ce)
			state <= next_state;
	end

	// Recovery timer, runs only while recovering
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			timer <= sio_pkg::CNT_RST;
		else if (ce)
			timer <= (state == sio_pkg::OCS_RECOVER) ? sio_pkg::sio_count(timer, tick)
				: sio_pkg::CNT_RST;
	end

	// Fault shown and channel held off outside ok
	assign fault = (state != sio_pkg::OCS_OK);
	assign allow = (state == sio_pkg::OCS_OK);
	assign failsafe_req = (state == sio_pkg::OCS_LOCKED) && (policy == sio_pkg::OCP_FAILSAFE);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_auto_trip: assert property (ce && en && overcurrent && state == sio_pkg::OCS_OK
		&& policy == sio_pkg::OCP_AUTO |=> fault && !allow)
		else $error("auto recovery trip missed");
	a_lock_hold: assert property (ce && state == sio_pkg::OCS_LOCKED && supply_ok
		|=> fault && !allow)
		else $error("locked channel released without supply cycle");
	c_auto_cycle: cover property (state == sio_pkg::OCS_RECOVER ##1 state == sio_pkg::OCS_OK);

endmodule : sio_ocp

`default_nettype wire

// >>> design/sio_pair.sv
/*
	Discrepancy monitor for one even/odd input pair.
	Assumes both inputs are already debounced and synchronous to mclk.
*/
`default_nettype none

module sio_pair (
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	// Configuration
	input wire logic en,
	input wire sio_pkg::sio_pair_e mode,
	input wire logic active_low,
	input wire logic [sio_pkg::CNT_W-1:0] disc_time,
	// Debounced pair and fault clear
	input wire logic even_in,
	input wire logic odd_in,
	input wire logic clear,
	// Results
	output logic fault,
	output logic value,
	output logic safe
);

	logic even_q; // Previous even level
	logic odd_q; // Previous odd level
	logic [1:0] cnt_even; // Even edges while odd held
	logic [1:0] cnt_odd; // Odd edges while even held
	logic [sio_pkg::CNT_W-1:0] timer; // Time out of relationship
	logic rel_ok; // Pair in required relationship
	logic even_chg; // Even changed this cycle
	logic odd_chg; // Odd changed this cycle
	logic expired; // Discrepancy time ran out
	logic trip; // Second lone toggle seen

	// Relationship and change detection on filtered levels
	assign rel_ok = (mode == sio_pkg::PAIR_EQUIV) ? (even_in == odd_in)
		: (even_in != odd_in);
	assign even_chg = even_in ^ even_q;
	assign odd_chg = odd_in ^ odd_q;
	assign expired = !rel_ok && (timer >= disc_time);
	assign trip = en && ((even_chg && !odd_chg && cnt_even == sio_pkg::EDGE_ONE)
		|| (odd_chg && !even_chg && cnt_odd == sio_pkg::EDGE_ONE));

	// Previous levels
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			even_q <= 1'b0;
			odd_q <= 1'b0;
		end
		else if (ce)
		begin
			even_q <= even_in;
			odd_q <= odd_in;
		end
	end

	// Lone toggle counters, one resets when the other moves
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_even <= sio_pkg::EDGE_RST;
			cnt_odd <= sio_pkg::EDGE_RST;
		end
		else if (ce)
		begin
			if (!en || (even_chg && odd_chg))
			begin
				cnt_even <= sio_pkg::EDGE_RST;
				cnt_odd <= sio_pkg::EDGE_RST;
			end
			else if (even_chg)
			begin
				cnt_even <= (cnt_even == sio_pkg::EDGE_LIMIT) ? cnt_even : cnt_even + sio_pkg::EDGE_ONE;
				cnt_odd <= sio_pkg::EDGE_RST;
			end
			else if (odd_chg)
			begin
				cnt_odd <= (cnt_odd == sio_pkg::EDGE_LIMIT) ? cnt_odd : cnt_odd + sio_pkg::EDGE_ONE;
				cnt_even <= sio_pkg::EDGE_RST;
			end
		end
	end

	// Discrepancy timer: runs out of relationship, restarts on return
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			timer <= sio_pkg::CNT_RST;
		else if (ce)
			timer <= (!en || rel_ok) ? sio_pkg::CNT_RST : sio_pkg::sio_count(timer, tick);
	end

	// Sticky fault, a new set wins over clear
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			fault <= 1'b0;
		else if (ce)
		begin
			if (en && (expired || trip))
				fault <= 1'b1;
			else if (clear || !en)
				fault <= 1'b0;
		end
	end

	// Reported value and safe-state indication
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			value <= 1'b0;
			safe <= 1'b0;
		end
		else if (ce)
		begin
			value <= even_in ^ active_low;
			safe <= !even_in && (odd_in == (mode == sio_pkg::PAIR_COMPL));
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_zero_time: assert property (ce && en && disc_time == sio_pkg::CNT_RST && !rel_ok
		|=> fault)
		else $error("zero discrepancy time did not fault");
	a_double_toggle: assert property (ce && en && even_chg && !odd_chg
		&& cnt_even == sio_pkg::EDGE_ONE |=> fault)
		else $error("second lone even toggle missed");
	c_pair_fault: cover property (!fault ##1 fault);

endmodule : sio_pair

`default_nettype wire

// >>> test/sio_field.sv
/*
	Field wiring model: internal sense tap and external readback loop.
	Assumes mclk is the design clock and output_channel the design drive.
*/
`default_nettype none

module sio_field (
	// Clock and drive
	input wire logic mclk,
	input wire logic output_channel,
	// Fault injection
	input wire logic sense_brk,
	input wire logic ext_stuck,
	// Sensed levels
	output logic out_sense,
	output logic ext_readback
);
	timeunit 1ns;
	timeprecision 1ns;
	// Three-cycle wire delay to the readback input
	logic [2:0] lag;
	// Sense tap sees the pin at once, broken on demand
	assign out_sense = output_channel ^ sense_brk;
	// Readback trails the pin
	always_ff @(posedge mclk)
	begin
		lag <= {lag[1:0], output_channel};
	end
	// A stuck loop reads low whatever the pin does
	assign ext_readback = ext_stuck ? 1'b0 : lag[2];
endmodule : sio_field

`default_nettype wire

// >>> test/sio_diag_tb_top.sv
/*
	Self-checking bench for the channel diagnostics.
	Assumes the field model stands on the output wiring.
*/
`default_nettype none

module sio_diag_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst_n, ce, out_cmd, pair_clear, out_load_low, out_overcurrent;
	logic even_in, odd_in, in_overcurrent, supply_ok, sense_brk, ext_stuck;
	logic out_sense, ext_readback, output_channel, failsafe, pair_value, pair_safe;
	logic output_readback_fault, output_overcurrent_fault, output_open_load_fault;
	logic input_overcurrent_fault, pair_mismatch_fault;
	sio_pkg::sio_out_cfg_s oc;
	sio_pkg::sio_in_cfg_s ic;
	int error_cnt = 0;
	int n_tests = 0;
	int seed = 32'h6bc6;

	// Clock, 10 ns
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	sio_diag dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce), .out_cfg(oc), .in_cfg(ic),
		.out_cmd(out_cmd), .pair_clear(pair_clear), .out_sense(out_sense),
		.ext_readback(ext_readback), .out_load_low(out_load_low),
		.out_overcurrent(out_overcurrent), .output_channel(output_channel),
		.even_in(even_in), .odd_in(odd_in), .in_overcurrent(in_overcurrent),
		.supply_ok(supply_ok), .output_readback_fault(output_readback_fault),
		.output_overcurrent_fault(output_overcurrent_fault),
		.output_open_load_fault(output_open_load_fault),
		.input_overcurrent_fault(input_overcurrent_fault),
		.pair_mismatch_fault(pair_mismatch_fault), .pair_value(pair_value),
		.pair_safe(pair_safe), .failsafe(failsafe));
	sio_field field_u (.mclk(mclk), .output_channel(output_channel),
		.sense_brk(sense_brk), .ext_stuck(ext_stuck), .out_sense(out_sense),
		.ext_readback(ext_readback));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("Checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic seen, input logic exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %b seen %b", nm, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	// Watched signal by index
	function automatic logic sig(input int k);
		case (k)
			0: sig = output_readback_fault;
			1: sig = output_overcurrent_fault;
			2: sig = pair_mismatch_fault;
			3: sig = output_channel;
			default: sig = failsafe;
		endcase
	endfunction : sig

	// Bounded wait; running out ends the run
	task automatic wait_sig(input int k, input logic v, input int lim, output int n);
		n = 0;
		while (sig(k) !== v && n < lim)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= lim)
		begin
			chk($sformatf("wait %0d", k), sig(k), v);
			give_verdict();
		end
	endtask : wait_sig

	// Reported pair value from the even input and active-low setting
	function automatic logic exp_val(input logic ev, input logic al);
		exp_val = ev ^ al;
	endfunction : exp_val

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		int n;
		rst_n = 1'b0;
		ce = 1'b1;
		{out_cmd, pair_clear, out_load_low, out_overcurrent, sense_brk, ext_stuck} = '0;
		{even_in, odd_in, in_overcurrent} = '0;
		supply_ok = 1'b1;
		oc = '0;
		ic = '0;
		cyc(16);
		rst_n = 1'b1;
		cyc(2);
		for (int k = 0; k < 5; k++)
			chk("idle flag", sig(k), 1'b0);
		// Internal readback
		out_cmd = 1'b1;
		cyc(2);
		chk("drive", output_channel, 1'b1);
		sense_brk = 1'b1;
		cyc(2);
		chk("rb int", output_readback_fault, 1'b1);
		sense_brk = 1'b0;
		cyc(2);
		chk("rb int clr", output_readback_fault, 1'b0);
		// Random slow toggling, paired inputs kept equal
		oc.ext_rb = 1'b1;
		oc.rb_delay = 16'h0003;
		ic.disc_en = 1'b1;
		ic.disc_time = 16'h0003;
		for (int i = 0; i < 20; i++)
		begin
			out_cmd = 1'($random(seed));
			even_in = 1'($random(seed));
			odd_in = even_in;
			ic.active_low = 1'($random(seed));
			cyc(300);
			chk("rb ext ok", output_readback_fault, 1'b0);
			chk("drive", output_channel, out_cmd);
			chk("pair ok", pair_mismatch_fault, 1'b0);
			chk("pair val", pair_value, exp_val(even_in, ic.active_low));
		end
		// External readback timing, then zero delay
		{even_in, odd_in, ic.active_low} = '0;
		out_cmd = 1'b1;
		cyc(10);
		ext_stuck = 1'b1;
		wait_sig(0, 1'b1, 500, n);
		chk("rb delay", n >= 190, 1'b1);
		ext_stuck = 1'b0;
		cyc(2);
		chk("rb ext clr", output_readback_fault, 1'b0);
		oc.rb_delay = 16'h0000;
		ext_stuck = 1'b1;
		cyc(3);
		chk("rb no delay", output_readback_fault, 1'b1);
		ext_stuck = 1'b0;
		oc.ext_rb = 1'b0;
		// Open load only while energized
		oc.ol_en = 1'b1;
		out_load_low = 1'b1;
		cyc(2);
		chk("open load", output_open_load_fault, 1'b1);
		out_cmd = 1'b0;
		cyc(3);
		chk("open load off", output_open_load_fault, 1'b0);
		out_load_low = 1'b0;
		out_cmd = 1'b1;
		// Overcurrent with auto recovery
		oc.oc_en = 1'b1;
		oc.oc_policy = sio_pkg::OCP_AUTO;
		oc.recov_time = 16'h0002;
		out_overcurrent = 1'b1;
		cyc(3);
		chk("oc trip", output_overcurrent_fault, 1'b1);
		chk("oc off", output_channel, 1'b0);
		out_overcurrent = 1'b0;
		ce = 1'b0;
		cyc(300);
		chk("oc frozen", output_overcurrent_fault, 1'b1);
		ce = 1'b1;
		wait_sig(1, 1'b0, 400, n);
		wait_sig(3, 1'b1, 5, n);
		// No recovery until supply cycles
		oc.oc_policy = sio_pkg::OCP_NONE;
		out_overcurrent = 1'b1;
		cyc(2);
		out_overcurrent = 1'b0;
		cyc(600);
		chk("oc lock", output_overcurrent_fault, 1'b1);
		chk("oc lock off", output_channel, 1'b0);
		supply_ok = 1'b0;
		cyc(1);
		supply_ok = 1'b1;
		wait_sig(1, 1'b0, 5, n);
		// Input overcurrent needs test pulses
		ic.oc_en = 1'b1;
		ic.oc_policy = sio_pkg::OCP_AUTO;
		in_overcurrent = 1'b1;
		cyc(3);
		chk("in oc no pulse", input_overcurrent_fault, 1'b0);
		ic.test_pulse = 1'b1;
		cyc(3);
		chk("in oc", input_overcurrent_fault, 1'b1);
		in_overcurrent = 1'b0;
		// Pair timer: short excursion, then a lasting one
		even_in = 1'b1;
		cyc(100);
		odd_in = 1'b1;
		cyc(500);
		chk("pair short", pair_mismatch_fault, 1'b0);
		even_in = 1'b0;
		wait_sig(2, 1'b1, 500, n);
		chk("pair time", n >= 190, 1'b1);
		odd_in = 1'b0;
		pair_clear = 1'b1;
		cyc(1);
		pair_clear = 1'b0;
		cyc(2);
		chk("pair clr", pair_mismatch_fault, 1'b0);
		// Double toggle of one input
		even_in = 1'b1;
		cyc(3);
		even_in = 1'b0;
		cyc(3);
		chk("pair toggle", pair_mismatch_fault, 1'b1);
		// Complementary safe state
		ic.disc_mode = sio_pkg::PAIR_COMPL;
		odd_in = 1'b1;
		cyc(3);
		chk("pair safe", pair_safe, 1'b1);
		// Failsafe policy latches until reset
		oc.oc_policy = sio_pkg::OCP_FAILSAFE;
		out_overcurrent = 1'b1;
		wait_sig(4, 1'b1, 5, n);
		out_overcurrent = 1'b0;
		cyc(600);
		chk("fs hold", failsafe, 1'b1);
		chk("fs off", output_channel, 1'b0);
		rst_n = 1'b0;
		cyc(2);
		chk("fs reset", failsafe, 1'b0);
		give_verdict();
	end
endmodule : sio_diag_tb_top

`default_nettype wire
